/* File: hw/ppb_init_filt.sv */
// Qualifies the host initialise line by its low time.
// Assumes init_n is synchronous to mclk.
`timescale 1ns/10ps
module ppb_init_filt
	import ppb_pkg::*;
#(
	parameter int INIT_CYC = PPB_INIT_CYC
) (
	input wire logic mclk,
	input wire logic srst,
	ppb_init_if.filt link
);
	import ppb_pkg::*;

	typedef struct packed {
		logic [15:0] low_cnt;
		logic fire;
	} ppb_filt_t;

	localparam logic [15:0] LIMIT = 16'(INIT_CYC);

	ppb_filt_t st;
	ppb_filt_t next_st;

	// ------------------------------------------------------------
	// Low time counter
	// ------------------------------------------------------------
	// Fires once when the line has been low for more than the limit.
	always_comb begin
		next_st = st;
		next_st.fire = 1'b0;
		if (link.init_n) begin
			next_st.low_cnt = 16'h0000;
		end else if (st.low_cnt <= LIMIT) begin
			next_st.low_cnt = st.low_cnt + 16'h0001;
			next_st.fire = (st.low_cnt == LIMIT);
		end
	end

	// Registers the filter state.
	always_ff @(posedge mclk) begin
		if (srst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign link.init_fire = st.fire;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_init_short;
		@(posedge mclk) disable iff (srst)
		$fell(link.init_n) |-> !link.init_fire [*8];
	endproperty
	a_init_short: assert property (p_init_short)
		else $error("Initialise acted on a short pulse.");

endmodule : ppb_init_filt

/* File: hw/ppb_init_if.sv */
// Carrier between the port core and its initialise pulse filter.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface ppb_init_if;
	logic init_n;
	logic init_fire;
	modport filt (input init_n, output init_fire);
	modport core (output init_n, input init_fire);
endinterface : ppb_init_if

/* File: hw/ppb_pkg.sv */
// Shared constants and types for the printer parallel byte port.
// Assumes a single 100 MHz clock and a word-wide AHB-Lite register bus.
package ppb_pkg;

	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int PPB_CLK_MHZ = 100;
	localparam int PPB_CLK_NS = 10;
	localparam int PPB_INIT_MIN_US = 50;
	localparam int PPB_INIT_CYC = PPB_INIT_MIN_US * PPB_CLK_MHZ;
	localparam int PPB_ACK_NS = 1000;
	localparam logic [7:0] PPB_ACK_CYC = 8'((PPB_ACK_NS + PPB_CLK_NS - 1) / PPB_CLK_NS);

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] PPB_OFF_CTRL = 8'h00;
	localparam logic [7:0] PPB_OFF_STATUS = 8'h04;
	localparam logic [7:0] PPB_OFF_DATA = 8'h08;
	localparam logic [7:0] PPB_OFF_IRQ_STAT = 8'h0C;
	localparam logic [7:0] PPB_OFF_IRQ_CLR = 8'h10;
	localparam logic [7:0] PPB_OFF_IRQ_EN = 8'h14;

	// ------------------------------------------------------------
	// Control register fields
	// ------------------------------------------------------------
	localparam int PPB_CTRL_SERIAL = 0;
	localparam int PPB_CTRL_BUSY_INV = 1;
	localparam int PPB_CTRL_PAUSED = 2;
	localparam int PPB_CTRL_SELECTED = 3;
	localparam int PPB_CTRL_PAPER_OUT = 4;
	localparam int PPB_CTRL_ERROR = 5;
	localparam logic [5:0] PPB_CTRL_RESET = 6'h08;

	// ------------------------------------------------------------
	// Status and interrupt fields
	// ------------------------------------------------------------
	localparam int PPB_ST_FULL = 0;
	localparam int PPB_ST_HOLD = 1;
	localparam int PPB_ST_ENGAGED = 2;
	localparam int PPB_IRQ_RX = 0;
	localparam int PPB_IRQ_INIT = 1;
	localparam int PPB_IRQ_OVERRUN = 2;
	localparam logic [2:0] PPB_IRQ_RESET = 3'h0;

	// Handshake states of the parallel receiver.
	typedef enum logic [1:0] {
		PPB_IDLE,
		PPB_BUSY,
		PPB_ACK
	} ppb_hs_t;

endpackage : ppb_pkg

/* File: hw/ppb_port.sv */
// Printer-side receiver for the parallel host port, with its register file.
// Assumes synchronous host pins and a single AHB-Lite master on mclk.
//
// The register offsets and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/10ps
module ppb_port
	import ppb_pkg::*;
#(
	parameter int INIT_CYC = ppb_pkg::PPB_INIT_CYC
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [7:0] host_data,
	input wire logic strobe_n,
	input wire logic init_n,
	output logic hold_off,
	output logic byte_taken_pulse_n,
	output logic paper_exhausted,
	output logic online_selected,
	output logic fault_flag_n,
	input wire logic ser_valid,
	input wire logic [7:0] ser_data,
	output logic ser_ready,
	output logic irq
);
	import ppb_pkg::*;

	typedef struct packed {
		ppb_hs_t hs;
		logic strobe_prev;
		logic [7:0] rx_byte;
		logic full;
		logic [7:0] ack_cnt;
		logic ack_again;
		logic [5:0] ctrl;
		logic [2:0] irq_stat;
		logic [2:0] irq_en;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic [31:0] rdata;
	} ppb_core_t;

	ppb_core_t st;
	ppb_core_t next_st;
	ppb_init_if init_link ();

	logic addr_ok;
	logic par_sel;
	logic engine_ok;
	logic hold_raw;
	logic strobe_fall;
	logic par_take;
	logic latch_open;
	logic ser_take;
	logic pop;
	logic [2:0] irq_set;
	logic [2:0] irq_clr;

	// Matches a transfer address against a register offset.
	function automatic logic ppb_hit(input logic [7:0] addr, input logic [7:0] off);
		ppb_hit = (addr == off);
	endfunction : ppb_hit

	// ------------------------------------------------------------
	// Initialise filter
	// ------------------------------------------------------------
	assign init_link.init_n = init_n;

	ppb_init_filt #(
		.INIT_CYC(INIT_CYC)
	) u_init (
		.mclk(mclk),
		.srst(srst),
		.link(init_link)
	);

	// ------------------------------------------------------------
	// Status terms
	// ------------------------------------------------------------
	// Port choice and the printer conditions that block intake.
	assign par_sel = !st.ctrl[PPB_CTRL_SERIAL];
	assign engine_ok = !st.ctrl[PPB_CTRL_PAUSED] && !st.ctrl[PPB_CTRL_ERROR];
	assign strobe_fall = st.strobe_prev && !strobe_n;
	assign addr_ok = hsel && htrans[1] && hready;
	assign pop = addr_ok && !hwrite && ppb_hit(haddr[7:0], PPB_OFF_DATA);

	// Hold-off covers serial mode, an open handshake, a full buffer, pause and error.
	assign hold_raw = !par_sel || (st.hs != PPB_IDLE) || st.full
		|| !engine_ok;

	// The latch is open while idle and during the acknowledge pulse, when the host may send.
	assign latch_open = (st.hs == PPB_IDLE) || (st.hs == PPB_ACK);

	// A parallel byte is taken only on a fresh latch edge with room free.
	assign par_take = par_sel && latch_open && strobe_fall && !st.full;
	assign ser_take = !par_sel && ser_valid && !st.full;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	// Handshake engine, receive buffer and register file in one step.
	always_comb begin
		next_st = st;
		irq_set = 3'h0;
		irq_clr = 3'h0;
		next_st.strobe_prev = strobe_n;
		// Handshake sequence of the parallel side.
		case (st.hs)
			PPB_IDLE: begin
				if (par_take) begin
					next_st.hs = PPB_BUSY;
				end
			end
			PPB_BUSY: begin
				if (strobe_n && !st.full && engine_ok) begin
					next_st.hs = PPB_ACK;
					next_st.ack_cnt = PPB_ACK_CYC;
				end
			end
			PPB_ACK: begin
				next_st.ack_cnt = st.ack_cnt - 8'h01;
				// A byte latched during the pulse earns an acknowledge of its own.
				if (par_take) begin
					next_st.ack_again = 1'b1;
				end
				if (st.ack_cnt == 8'h01) begin
					next_st.hs = (st.ack_again || par_take) ? PPB_BUSY : PPB_IDLE;
					next_st.ack_again = 1'b0;
				end
			end
			default: begin
				next_st.hs = PPB_IDLE;
			end
		endcase
		// A latch edge against a full buffer loses the byte.
		if (par_sel && strobe_fall && latch_open && st.full) begin
			irq_set[PPB_IRQ_OVERRUN] = 1'b1;
		end
		// Buffer pop by software read, then fill; a fill beats a pop.
		if (pop) begin
			next_st.full = 1'b0;
		end
		if (par_take) begin
			next_st.rx_byte = host_data;
			next_st.full = 1'b1;
			irq_set[PPB_IRQ_RX] = 1'b1;
		end else if (ser_take) begin
			next_st.rx_byte = ser_data;
			next_st.full = 1'b1;
			irq_set[PPB_IRQ_RX] = 1'b1;
		end
		// Bus address phase: capture write target, prepare read data.
		next_st.wr_pend = addr_ok && hwrite;
		if (addr_ok) begin
			next_st.wr_addr = haddr[7:0];
		end
		if (addr_ok && !hwrite) begin
			case (1'b1)
				ppb_hit(haddr[7:0], PPB_OFF_CTRL): next_st.rdata = {26'h0, st.ctrl};
				ppb_hit(haddr[7:0], PPB_OFF_STATUS): next_st.rdata = {29'h0,
					(st.hs != PPB_IDLE), hold_raw, st.full};
				ppb_hit(haddr[7:0], PPB_OFF_DATA): next_st.rdata = {24'h0, st.rx_byte};
				ppb_hit(haddr[7:0], PPB_OFF_IRQ_STAT): next_st.rdata = {29'h0, st.irq_stat};
				ppb_hit(haddr[7:0], PPB_OFF_IRQ_EN): next_st.rdata = {29'h0, st.irq_en};
				default: next_st.rdata = 32'h0000_0000;
			endcase
		end
		// Bus data phase: apply the write.
		if (st.wr_pend) begin
			if (ppb_hit(st.wr_addr, PPB_OFF_CTRL)) begin
				next_st.ctrl = hwdata[5:0];
			end
			if (ppb_hit(st.wr_addr, PPB_OFF_IRQ_CLR)) begin
				irq_clr = hwdata[2:0];
			end
			if (ppb_hit(st.wr_addr, PPB_OFF_IRQ_EN)) begin
				next_st.irq_en = hwdata[2:0];
			end
		end
		// Host initialise returns the receiver to its start.
		if (init_link.init_fire) begin
			next_st.hs = PPB_IDLE;
			next_st.full = 1'b0;
			next_st.ack_cnt = 8'h00;
			next_st.ack_again = 1'b0;
			irq_set[PPB_IRQ_INIT] = 1'b1;
		end
		// Sticky events: a new event wins over a clear in the same cycle.
		next_st.irq_stat = (st.irq_stat & ~irq_clr) | irq_set;
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	// Registers the whole core state.
	always_ff @(posedge mclk) begin
		if (srst) begin
			st <= '0;
			st.hs <= PPB_IDLE;
			st.strobe_prev <= 1'b1;
			st.ctrl <= PPB_CTRL_RESET;
			st.irq_stat <= PPB_IRQ_RESET;
			st.irq_en <= PPB_IRQ_RESET;
		end else begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Pin levels derived from registered state.
	assign hold_off = hold_raw ^ st.ctrl[PPB_CTRL_BUSY_INV];
	assign byte_taken_pulse_n = (st.hs != PPB_ACK);
	assign paper_exhausted = st.ctrl[PPB_CTRL_PAPER_OUT];
	assign online_selected = st.ctrl[PPB_CTRL_SELECTED] && !st.ctrl[PPB_CTRL_ERROR];
	assign fault_flag_n = !st.ctrl[PPB_CTRL_ERROR];
	assign ser_ready = !par_sel && !st.full;
	assign irq = |(st.irq_stat & st.irq_en);

	// Bus answers: zero wait, always OKAY.
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = st.rdata;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (srst);

	sequence s_release;
		(st.hs == PPB_BUSY) && strobe_n && !st.full && engine_ok;
	endsequence

	sequence s_ack_run;
		!byte_taken_pulse_n [*8];
	endsequence

	property p_serial_take;
		!par_sel && ser_valid && ser_ready && !init_link.init_fire
			|=> st.full && (st.rx_byte == $past(ser_data));
	endproperty
	a_serial_take: assert property (p_serial_take)
		else $error("Serial byte not taken.");

	property p_data_read;
		pop && !par_take && !ser_take |=> hrdata == {24'h0, $past(st.rx_byte)};
	endproperty
	a_data_read: assert property (p_data_read)
		else $error("Data read does not return the held byte.");

	property p_capture;
		par_sel && latch_open && strobe_fall && !st.full && !init_link.init_fire
			|=> st.full && (st.rx_byte == $past(host_data));
	endproperty
	a_capture: assert property (p_capture)
		else $error("Latched byte not captured.");

	property p_hold_strobe;
		par_sel && strobe_fall |=> hold_raw;
	endproperty
	a_hold_strobe: assert property (p_hold_strobe)
		else $error("Hold-off missing after latch edge.");

	property p_hold_full;
		st.full |-> hold_raw && (hold_off != st.ctrl[PPB_CTRL_BUSY_INV]);
	endproperty
	a_hold_full: assert property (p_hold_full)
		else $error("Hold-off low with a full buffer.");

	property p_hold_pause;
		(st.ctrl[PPB_CTRL_PAUSED] || st.ctrl[PPB_CTRL_ERROR]) && !st.ctrl[PPB_CTRL_BUSY_INV]
			|-> hold_off;
	endproperty
	a_hold_pause: assert property (p_hold_pause)
		else $error("Hold-off low while paused or in error.");

	property p_polarity;
		st.ctrl[PPB_CTRL_BUSY_INV] && st.full |-> !hold_off;
	endproperty
	a_polarity: assert property (p_polarity)
		else $error("Inverted hold-off polarity not applied.");

	property p_ack;
		s_release and !init_link.init_fire |=> s_ack_run;
	endproperty
	a_ack: assert property (p_ack)
		else $error("Acknowledge pulse missing or too short.");

	property p_ack_ready;
		$fell(byte_taken_pulse_n) |-> !$past(st.full) && $past(engine_ok);
	endproperty
	a_ack_ready: assert property (p_ack_ready)
		else $error("Acknowledge sent while not ready.");

	property p_error_pins;
		st.ctrl[PPB_CTRL_ERROR] |-> !online_selected && !fault_flag_n;
	endproperty
	a_error_pins: assert property (p_error_pins)
		else $error("Error not shown on status pins.");

	property p_init;
		init_link.init_fire |=> !st.full && (st.hs == PPB_IDLE) && st.irq_stat[PPB_IRQ_INIT];
	endproperty
	a_init: assert property (p_init)
		else $error("Initialise did not reset the port.");

	property p_overrun;
		par_sel && strobe_fall && latch_open && st.full |=> st.irq_stat[PPB_IRQ_OVERRUN];
	endproperty
	a_overrun: assert property (p_overrun)
		else $error("Latch edge against a full buffer not flagged.");

	property p_ack_take;
		par_take && (st.hs == PPB_ACK) && !init_link.init_fire
			|=> st.full && (st.hs != PPB_IDLE);
	endproperty
	a_ack_take: assert property (p_ack_take)
		else $error("Byte latched during acknowledge was lost.");

	property p_ack_cause;
		$fell(byte_taken_pulse_n) |-> $past(st.hs == PPB_BUSY);
	endproperty
	a_ack_cause: assert property (p_ack_cause)
		else $error("Acknowledge sent with no byte received.");

endmodule : ppb_port

/* File: sim/ppb_host.sv */
// Host computer model for the parallel printer port.
// Assumes it shares mclk with the port and is driven by calls from the bench.
`timescale 1ns/10ps
module ppb_host (
	input wire logic mclk,
	input wire logic hold_off,
	output logic [7:0] host_data,
	output logic strobe_n,
	output logic init_n
);
	// Lines rest at their idle levels from time zero.
	initial begin
		host_data = 8'h00;
		strobe_n = 1'b1;
		init_n = 1'b1;
	end

	// Pulses the latch low for two cycles without looking at hold-off.
	task automatic latch_pulse;
		strobe_n <= 1'b0;
		repeat (2) @(posedge mclk);
		strobe_n <= 1'b1;
		@(posedge mclk);
	endtask : latch_pulse

	// Waits for room, then presents a byte and pulses the latch; late marks a wait that ran out.
	task automatic send_byte(input logic [7:0] b, output logic late);
		int n;
		n = 0;
		while (hold_off !== 1'b0 && n < 500) begin
			@(posedge mclk);
			n++;
		end
		late = (n >= 500);
		host_data <= b;
		@(posedge mclk);
		latch_pulse();
		host_data <= ~b;
	endtask : send_byte

	// Holds the initialise line low for the given number of cycles.
	task automatic init_pulse(input int cyc);
		init_n <= 1'b0;
		repeat (cyc) @(posedge mclk);
		init_n <= 1'b1;
		@(posedge mclk);
	endtask : init_pulse
endmodule : ppb_host

/* File: sim/ppb_port_tb.sv */
// Self-checking bench for the parallel byte port, with a host model.
// Assumes the port is the only AHB-Lite slave, so hready is its hreadyout.
`timescale 1ns/10ps
module ppb_port_tb;
	import ppb_pkg::*;
	logic mclk, srst, hsel, hwrite, hready, hresp, irq, ser_valid, ser_ready;
	logic hold_off, byte_taken_pulse_n, paper_exhausted, online_selected, fault_flag_n;
	logic strobe_n, init_n;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [7:0] host_data, ser_data;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [5:0] cv [6] = '{6'h08, 6'h0C, 6'h28, 6'h18, 6'h00, 6'h0A};
	logic [3:0] ev [6] = '{4'h3, 4'hB, 4'h8, 4'h7, 4'h1, 4'hB};
	logic held;
	int error_cnt, checks_done, n;

	ppb_port #(.INIT_CYC(20)) DUT (.mclk(mclk), .srst(srst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .host_data(host_data),
		.strobe_n(strobe_n), .init_n(init_n), .hold_off(hold_off),
		.byte_taken_pulse_n(byte_taken_pulse_n), .paper_exhausted(paper_exhausted),
		.online_selected(online_selected), .fault_flag_n(fault_flag_n),
		.ser_valid(ser_valid), .ser_data(ser_data), .ser_ready(ser_ready), .irq(irq));

	ppb_host HOST (.mclk(mclk), .hold_off(hold_off), .host_data(host_data),
		.strobe_n(strobe_n), .init_n(init_n));

	// Compares one value and counts the outcome.
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : chk

	// Prints the counts and the verdict, then ends the run.
	task automatic results;
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : results

	// Waits for the slave to be ready at a rising edge, with a bound.
	task automatic rdy;
		@(posedge mclk);
		for (int k = 0; hready !== 1'b1; k++) begin
			if (k > 50) begin
				error_cnt++;
				results();
			end
			@(posedge mclk);
		end
	endtask : rdy

	// One single word transfer; read data lands in rd.
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr <= {24'h000000, a};
		rdy();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		rdy();
		rd = hrdata;
	endtask : bus

	// Waits, with a bound, for the acknowledge line to go low.
	task automatic wait_ack;
		#1;
		for (int k = 0; byte_taken_pulse_n !== 1'b0; k++) begin
			if (k > 400) begin
				error_cnt++;
				results();
			end
			@(posedge mclk);
			#1;
		end
	endtask : wait_ack

	// Sends one byte through the host model; a host that never gets room ends the run.
	task automatic send(input logic [7:0] b);
		logic late;
		HOST.send_byte(b, late);
		if (late !== 1'b0) begin
			error_cnt++;
			results();
		end
	endtask : send

	// Free-running 100 MHz clock.
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// Main sequence of tests.
	initial begin
		{srst, hsel, hwrite, ser_valid} = 4'h8;
		htrans = 2'b00;
		hsize = 3'h2;
		haddr = 32'h00000000;
		hwdata = 32'h00000000;
		ser_data = 8'h00;
		error_cnt = 0;
		checks_done = 0;
		repeat (2) @(posedge mclk);
		srst <= 1'b0;
		@(posedge mclk);
		#1;
		chk("pins", {hold_off, byte_taken_pulse_n, paper_exhausted, online_selected,
			fault_flag_n}, 32'h0000000B);
		chk("hresp", hresp, 1'b0);
		bus(0, PPB_OFF_CTRL, 0);
		chk("ctrl", rd, 32'h00000008);
		bus(1, PPB_OFF_STATUS, 32'hFFFFFFFF);
		bus(0, PPB_OFF_STATUS, 0);
		chk("status", rd, 32'h00000000);
		bus(0, 8'h40, 0);
		chk("unmapped", rd, 32'h00000000);
		$display("test reset done");
		bus(1, PPB_OFF_IRQ_EN, 32'h00000001);
		send(8'hA5);
		#1;
		chk("hold", hold_off, 1'b1);
		repeat (20) @(posedge mclk);
		#1;
		chk("hold full", {hold_off, irq}, 2'b11);
		bus(0, PPB_OFF_STATUS, 0);
		chk("status", rd, 32'h00000007);
		bus(0, PPB_OFF_DATA, 0);
		chk("data", rd, 32'h000000A5);
		wait_ack();
		n = 0;
		held = 1'b1;
		while (byte_taken_pulse_n === 1'b0 && n < 300) begin
			held &= hold_off;
			@(posedge mclk);
			#1;
			n++;
		end
		chk("ack width", n, PPB_ACK_CYC);
		chk("hold in ack", held, 1'b1);
		repeat (2) @(posedge mclk);
		#1;
		chk("hold free", hold_off, 1'b0);
		bus(0, PPB_OFF_IRQ_STAT, 0);
		chk("irq stat", rd, 32'h00000001);
		bus(1, PPB_OFF_IRQ_CLR, 32'h00000001);
		#1;
		chk("irq", irq, 1'b0);
		$display("test parallel byte done");
		for (int i = 0; i < 6; i++) begin
			bus(1, PPB_OFF_CTRL, {26'h0, cv[i]});
			#1;
			chk("ctrl pins", {hold_off, paper_exhausted, online_selected, fault_flag_n},
				ev[i]);
		end
		$display("test control pins done");
		bus(1, PPB_OFF_IRQ_EN, 32'h00000000);
		bus(1, PPB_OFF_CTRL, 32'h00000009);
		#1;
		chk("serial", {hold_off, ser_ready}, 2'b11);
		ser_data <= 8'h3C;
		ser_valid <= 1'b1;
		@(posedge mclk);
		ser_valid <= 1'b0;
		@(posedge mclk);
		#1;
		chk("masked irq", irq, 1'b0);
		bus(1, PPB_OFF_CTRL, 32'h00000008);
		HOST.latch_pulse();
		bus(0, PPB_OFF_IRQ_STAT, 0);
		chk("overrun", rd, 32'h00000005);
		bus(0, PPB_OFF_DATA, 0);
		chk("serial data", rd, 32'h0000003C);
		bus(1, PPB_OFF_IRQ_CLR, 32'h00000007);
		$display("test serial done");
		send(8'h96);
		bus(0, PPB_OFF_DATA, 0);
		chk("data", rd, 32'h00000096);
		wait_ack();
		HOST.latch_pulse();
		bus(0, PPB_OFF_STATUS, 0);
		chk("status in ack", rd, 32'h00000007);
		bus(0, PPB_OFF_DATA, 0);
		chk("data in ack", rd, 32'h00000069);
		n = 0;
		while (byte_taken_pulse_n === 1'b0 && n < 300) begin
			@(posedge mclk);
			#1;
			n++;
		end
		chk("ack gap", byte_taken_pulse_n, 1'b1);
		wait_ack();
		bus(0, PPB_OFF_STATUS, 0);
		chk("second ack", rd, 32'h00000006);
		$display("test latch in acknowledge done");
		send(8'h5A);
		HOST.init_pulse(10);
		bus(0, PPB_OFF_STATUS, 0);
		chk("short init", rd, 32'h00000007);
		HOST.init_pulse(25);
		bus(0, PPB_OFF_STATUS, 0);
		chk("long init", rd, 32'h00000000);
		bus(0, PPB_OFF_IRQ_STAT, 0);
		chk("init stat", rd, 32'h00000003);
		$display("test initialise done");
		results();
	end
endmodule : ppb_port_tb
